// ### dsp_core_regs.sv
// Core register model: W array, stack, status, page, shadows, prefetch, exceptions
`timescale 1ns/1ns
`include "core_regs_defines.svh"
module dsp_core_regs
    import core_regs_pkg::*;
(
    // Clock and reset
    input  wire logic                   clk,
    input  wire logic                   rst,
    // Program memory
    output logic [`PC_WIDTH-1:0]        progAddr,
    input  wire logic [`INSN_WIDTH-1:0] progData,
    // Execute-stage controls
    input  wire wreg_wr_s               wrPort,
    input  wire logic [3:0]             rdSel,
    input  wire logic                   pcLoad,
    input  wire logic [`PC_WIDTH-1:0]   pcTarget,
    input  wire logic                   stall,
    input  wire logic                   spPush,
    input  wire logic                   spPop,
    input  wire logic                   shadowPush,
    input  wire logic                   shadowPop,
    input  wire logic                   loopStart,
    input  wire logic                   loopEnd,
    input  wire logic [15:0]            loopStartIn,
    input  wire logic [15:0]            loopEndIn,
    input  wire logic [15:0]            loopCountIn,
    input  wire logic                   srWrEn,
    input  wire logic [15:0]            srWrData,
    input  wire logic                   psvWrEn,
    input  wire logic [7:0]             psvWrData,
    input  wire logic                   tblWrEn,
    input  wire logic [7:0]             tblWrData,
    input  wire logic                   repeatActive,
    // Data access request
    input  wire dmem_req_s              dReq,
    input  wire logic                   tblRead,
    // Shifter
    input  wire logic                   shiftEn,
    input  wire logic [`ACC_WIDTH-1:0]  shiftIn,
    input  wire logic signed [5:0]      shiftAmt,
    // Exceptions
    input  wire logic [`NUM_TRAPS-1:0]  trapReq,
    input  wire logic [`NUM_IRQS-1:0]   irqReq,
    input  wire logic [3*`NUM_IRQS-1:0] irqPrio,
    // Outputs
    output logic [15:0]                 rdData,
    output logic [15:0]                 spOut,
    output logic [15:0]                 statusOut,
    output logic [7:0]                  psvPageOut,
    output logic [`INSN_WIDTH-1:0]      insnOut,
    output logic                        psvBusy,
    output logic [`PC_WIDTH-1:0]        psvProgAddr,
    output logic [`INSN_WIDTH-1:0]      dataOut,
    output logic                        dataValid,
    output logic                        xSel,
    output logic                        excTaken,
    output logic [5:0]                  excVector,
    output logic [15:0]                 stackWrAddr,
    output logic [15:0]                 stackWrData,
    output logic                        stackWrEn,
    output logic [`ACC_WIDTH-1:0]       shiftOut
);
    logic [15:0] wreg [`NUM_WREGS];
    logic [15:0] next_wreg [`NUM_WREGS];
    logic [15:0] shadowW [4];
    logic [15:0] next_shadowW [4];
    logic [15:0] shadowSr, next_shadowSr;
    logic [15:0] loopRegs [3];
    logic [15:0] next_loopRegs [3];
    logic [15:0] loopShadow [3];
    logic [15:0] next_loopShadow [3];
    logic [15:0] sr, next_sr;
    logic [7:0]  psvPage, next_psvPage, tblPage, next_tblPage;
    logic [`PC_WIDTH-1:0] pc, next_pc;
    logic [`INSN_WIDTH-1:0] prefetch, next_prefetch;
    logic        psvPend, next_psvPend;
    exc_s        win;
    logic [`ACC_WIDTH-1:0] shiftRes;

    typedef enum logic [1:0] {EX_IDLE, EX_PUSH_PC, EX_PUSH_SR} exc_state_e;
    exc_state_e  excState, next_excState;
    logic [5:0]  excVec, next_excVec;

    exc_arbiter u_arb (
        .trapReq (trapReq),
        .irqReq  (irqReq),
        .irqPrio (irqPrio),
        .cpuPrio (sr[`SR_IPL_LO+2:`SR_IPL_LO]),
        .win     (win)
    );

    barrel_shift u_shift (
        .din    (shiftIn),
        .amount (shiftAmt),
        .dout   (shiftRes)
    );

    // Window hit: data read with address top bit set
    logic psvHit;
    assign psvHit = dReq.rdEn && dReq.addr[`PSV_WINDOW_BIT];

    always_comb begin
        for (int i = 0; i < `NUM_WREGS; i++)
            next_wreg[i] = wreg[i];
        for (int i = 0; i < 4; i++)
            next_shadowW[i] = shadowW[i];
        for (int i = 0; i < 3; i++) begin
            next_loopRegs[i]   = loopRegs[i];
            next_loopShadow[i] = loopShadow[i];
        end
        next_shadowSr = shadowSr;
        next_sr       = sr;
        next_psvPage  = psvWrEn ? psvWrData : psvPage;
        next_tblPage  = tblWrEn ? tblWrData : tblPage;
        next_excState = excState;
        next_excVec   = excVec;
        next_psvPend  = 1'b0;

        if (wrPort.wrEn) begin
            if (wrPort.isByte)
                next_wreg[wrPort.addr][7:0] = wrPort.data[7:0];
            else
                next_wreg[wrPort.addr] = wrPort.data;
        end
        if (spPush)
            next_wreg[`SP_INDEX] = wreg[`SP_INDEX] + 16'h0002;
        else if (spPop)
            next_wreg[`SP_INDEX] = wreg[`SP_INDEX] - 16'h0002;
        next_wreg[`SP_INDEX][0] = 1'b0;

        if (srWrEn)
            next_sr = srWrData;
        next_sr[`SR_RA] = repeatActive;
        if (loopStart) begin
            next_sr[`SR_DA] = 1'b1;
            for (int i = 0; i < 3; i++)
                next_loopShadow[i] = loopRegs[i];
            next_loopRegs[0] = loopStartIn;
            next_loopRegs[1] = loopEndIn;
            next_loopRegs[2] = loopCountIn;
        end else if (loopEnd) begin
            next_sr[`SR_DA] = 1'b0;
            for (int i = 0; i < 3; i++)
                next_loopRegs[i] = loopShadow[i];
        end

        if (shadowPush) begin
            for (int i = 0; i < 4; i++)
                next_shadowW[i] = wreg[i];
            next_shadowSr = sr & `SHADOW_FLAGS;
        end else if (shadowPop) begin
            for (int i = 0; i < 4; i++)
                next_wreg[i] = shadowW[i];
            next_sr = (next_sr & ~`SHADOW_FLAGS) | (shadowSr & `SHADOW_FLAGS);
        end

        // Window read holds one extra cycle
        if (psvHit && !psvPend)
            next_psvPend = 1'b1;

        // Exception entry: push PC low word, then status low with PC top
        unique case (excState)
            EX_IDLE: begin
                if (win.valid && !psvPend) begin
                    next_excState = EX_PUSH_PC;
                    next_excVec   = win.vector;
                end
            end
            EX_PUSH_PC: begin
                next_excState = EX_PUSH_SR;
                next_wreg[`SP_INDEX] = wreg[`SP_INDEX] + 16'h0002;
            end
            EX_PUSH_SR: begin
                next_excState = EX_IDLE;
                next_wreg[`SP_INDEX] = wreg[`SP_INDEX] + 16'h0002;
                if (excVec >= 6'(`NUM_TRAPS))
                    next_sr[`SR_IPL_LO+2:`SR_IPL_LO] = win.prio[2:0];
                else
                    next_sr[`SR_IPL_LO+2:`SR_IPL_LO] = 3'h7;
            end
        endcase
    end

    // Prefetch one word ahead of execute
    always_comb begin
        next_pc       = pc;
        next_prefetch = prefetch;
        if (excState == EX_PUSH_SR)
            next_pc = {15'h0000, excVec, 2'b00};
        else if (pcLoad)
            next_pc = {1'b0, pcTarget[`PC_WIDTH-2:1], 1'b0};
        else if (!stall && !(psvHit && !psvPend) && excState == EX_IDLE) begin
            next_pc       = pc + 23'h000002;
            next_prefetch = progData;
        end
        next_pc[0] = 1'b0;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            for (int i = 0; i < `NUM_WREGS; i++)
                wreg[i] <= 16'h0000;
            wreg[`SP_INDEX] <= `SP_RESET;
            for (int i = 0; i < 4; i++)
                shadowW[i] <= 16'h0000;
            for (int i = 0; i < 3; i++) begin
                loopRegs[i]   <= 16'h0000;
                loopShadow[i] <= 16'h0000;
            end
            shadowSr <= 16'h0000;
            sr       <= `SR_RESET;
            psvPage  <= `PSV_RESET;
            tblPage  <= `TBL_RESET;
            pc       <= `PC_RESET;
            prefetch <= '0;
            psvPend  <= 1'b0;
            excState <= EX_IDLE;
            excVec   <= 6'h00;
        end else begin
            for (int i = 0; i < `NUM_WREGS; i++)
                wreg[i] <= next_wreg[i];
            shadowW    <= next_shadowW;
            loopRegs   <= next_loopRegs;
            loopShadow <= next_loopShadow;
            shadowSr   <= next_shadowSr;
            sr         <= next_sr;
            psvPage    <= next_psvPage;
            tblPage    <= next_tblPage;
            pc         <= next_pc;
            prefetch   <= next_prefetch;
            psvPend    <= next_psvPend;
            excState   <= next_excState;
            excVec     <= next_excVec;
        end
    end

    // Registered outputs
    logic [`INSN_WIDTH-1:0] next_dataOut;
    logic [`PC_WIDTH-1:0]   next_psvProgAddr;
    always_comb begin
        next_psvProgAddr = {psvPage, dReq.addr[14:1], 1'b0};
        if (tblRead)
            next_dataOut = progData;
        else
            next_dataOut = {8'h00, progData[15:0]};
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rdData      <= 16'h0000;
            spOut       <= `SP_RESET;
            statusOut   <= `SR_RESET;
            psvPageOut  <= `PSV_RESET;
            insnOut     <= '0;
            psvBusy     <= 1'b0;
            psvProgAddr <= '0;
            dataOut     <= '0;
            dataValid   <= 1'b0;
            xSel        <= 1'b0;
            excTaken    <= 1'b0;
            excVector   <= 6'h00;
            stackWrAddr <= 16'h0000;
            stackWrData <= 16'h0000;
            stackWrEn   <= 1'b0;
            progAddr    <= `PC_RESET;
            shiftOut    <= '0;
        end else begin
            rdData      <= (rdSel == `SP_INDEX) ? {wreg[rdSel][15:1], 1'b0} : wreg[rdSel];
            spOut       <= {next_wreg[`SP_INDEX][15:1], 1'b0};
            statusOut   <= next_sr;
            psvPageOut  <= next_psvPage;
            insnOut     <= prefetch;
            psvBusy     <= next_psvPend;
            psvProgAddr <= next_psvProgAddr;
            dataOut     <= next_dataOut;
            dataValid   <= (psvHit && psvPend) || tblRead || (dReq.rdEn && !psvHit);
            xSel        <= dReq.rdEn || dReq.wrEn;
            excTaken    <= excState == EX_PUSH_SR;
            excVector   <= excVec;
            stackWrEn   <= excState != EX_IDLE;
            stackWrAddr <= wreg[`SP_INDEX];
            if (excState == EX_PUSH_PC)
                stackWrData <= pc[15:0];
            else
                stackWrData <= {sr[7:0], 1'b0, pc[`PC_WIDTH-1:16]};
            progAddr    <= next_pc;
            shiftOut    <= shiftEn ? shiftRes : shiftOut;
        end
    end

    // Checks
    a_sp_reset_val: assert property (@(posedge clk) $fell(rst) |-> spOut == `SP_RESET)
        else $error("stack pointer not at reset value");
    a_sp_aligned: assert property (@(posedge clk) disable iff (rst) spOut[0] == 1'b0)
        else $error("stack pointer misaligned");
    a_pc_even: assert property (@(posedge clk) disable iff (rst) progAddr[0] == 1'b0)
        else $error("program counter odd");
    a_psv_extra_cycle: assert property (@(posedge clk) disable iff (rst)
        (psvHit && !psvPend) |=> psvPend)
        else $error("window access without extra cycle");
    a_psv_low_only: assert property (@(posedge clk) disable iff (rst)
        !$past(tblRead) |-> dataOut[23:16] == 8'h00)
        else $error("window data upper bits set");
    sequence s_exc_enter;
        excState == EX_IDLE && win.valid && !psvPend;
    endsequence
    a_exc_two_pushes: assert property (@(posedge clk) disable iff (rst)
        s_exc_enter |=> (excState == EX_PUSH_PC) ##1 (excState == EX_PUSH_SR) ##1 excTaken)
        else $error("exception did not push two words");
    a_shadow_flags: assert property (@(posedge clk) disable iff (rst)
        shadowPush |=> shadowSr == ($past(sr) & `SHADOW_FLAGS)
        && shadowW[0] == $past(wreg[0]))
        else $error("shadow held non-shadowed flags");
    a_loop_active: assert property (@(posedge clk) disable iff (rst)
        (loopStart && !srWrEn) |=> sr[`SR_DA])
        else $error("loop active flag not set");
    a_byte_write: assert property (@(posedge clk) disable iff (rst)
        (wrPort.wrEn && wrPort.isByte && wrPort.addr < 4'h4 && !shadowPop)
        |=> wreg[$past(wrPort.addr)][15:8] == $past(wreg[wrPort.addr][15:8]))
        else $error("byte write touched high byte");
endmodule

// ### core_regs_defines.svh
// Constants for the core register model: field positions, reset values, widths
// Operation
// - Instructions are 24-bit words
// - PC is 23 bits, bit 0 clear
// - Sixteen 16-bit working registers, last is stack
// - 64 KB data space, fixed X/Y split (xSel here is set on every data access, no address split)
// - Upper 32 KB maps program space via page
// - Window access: extra cycle, low 16 bits
// - Table access reaches all 24 bits
// - Bit-reverse on X destinations, modulo both (no bit-reverse or modulo addressing here)
// - One read, write, register, fetch per cycle
// - Shift up to 16; two 40-bit accumulators (no accumulators here, only the 40-bit shifter)
// - Single-stage prefetch, one cycle ahead
// - 62 vectors: 8 traps, 54 interrupts
// - Interrupt priority 1..7, natural order ties
// - Traps fixed priority 8..15
// - Shadow push/pop W0-W3 and five flags
// - Loop registers shadowed on loop start/end
// - Byte op changes only low byte
// - Stack pointer bit 0 reads zero
// - Stack pointer resets to 0x0800
// - Exception pushes status low with PC top
// - Status layout: low and high bytes
// - Loops interruptible, no count overhead
`ifndef CORE_REGS_DEFINES_SVH
`define CORE_REGS_DEFINES_SVH
`define INSN_WIDTH      24
`define PC_WIDTH        23
`define NUM_WREGS       16
`define SP_INDEX        4'hF
`define SP_RESET        16'h0800
`define SR_RESET        16'h0000
`define PSV_RESET       8'h00
`define TBL_RESET       8'h00
`define PC_RESET        23'h000000
`define PSV_WINDOW_BIT  15
`define NUM_TRAPS       8
`define NUM_IRQS        54
`define NUM_VECTORS     62
`define TRAP_PRIO_BASE  4'h8
`define SR_C            0
`define SR_Z            1
`define SR_OV           2
`define SR_N            3
`define SR_RA           4
`define SR_IPL_LO       5
`define SR_DC           8
`define SR_DA           9
`define SR_SAB          10
`define SR_OAB          11
`define SR_SB           12
`define SR_SA           13
`define SR_OB           14
`define SR_OA           15
`define SHADOW_FLAGS    16'h010F
`define SHIFT_MAX       5'h10
`define ACC_WIDTH       40
`endif

// ### core_regs_pkg.sv
// Types shared by the core register model
package core_regs_pkg;
    typedef enum logic [1:0] {SZ_WORD, SZ_BYTE} opsize_e;
    typedef struct packed {
        logic        wrEn;
        logic [3:0]  addr;
        logic [15:0] data;
        logic        isByte;
    } wreg_wr_s;
    typedef struct packed {
        logic        rdEn;
        logic        wrEn;
        logic [15:0] addr;
        logic [15:0] wdata;
    } dmem_req_s;
    typedef struct packed {
        logic        valid;
        logic [5:0]  vector;
        logic [3:0]  prio;
    } exc_s;
endpackage

// ### exc_arbiter.sv
// Exception priority arbiter: traps above interrupts, natural-order ties
`timescale 1ns/1ns
`include "core_regs_defines.svh"
module exc_arbiter
    import core_regs_pkg::*;
(
    // Requests
    input  wire logic [`NUM_TRAPS-1:0]    trapReq,
    input  wire logic [`NUM_IRQS-1:0]     irqReq,
    input  wire logic [3*`NUM_IRQS-1:0]   irqPrio,
    input  wire logic [2:0]               cpuPrio,
    // Winner
    output exc_s                          win
);
    logic [`NUM_IRQS-1:0][2:0] prioArr;
    assign prioArr = irqPrio;

    always_comb begin
        win = '0;
        // Lower index wins ties, so scan downward and take >=
        for (int i = `NUM_IRQS-1; i >= 0; i--) begin
            if (irqReq[i] && prioArr[i] != 3'h0 && prioArr[i] > cpuPrio
                && {1'b0, prioArr[i]} >= win.prio) begin
                win.valid  = 1'b1;
                win.vector = 6'(i + `NUM_TRAPS);
                win.prio   = {1'b0, prioArr[i]};
            end
        end
        // Traps always outrank: 8 + trap index
        for (int t = 0; t < `NUM_TRAPS; t++) begin
            if (trapReq[t]) begin
                win.valid  = 1'b1;
                win.vector = 6'(t);
                win.prio   = `TRAP_PRIO_BASE + 4'(t);
            end
        end
    end
endmodule

// ### barrel_shift.sv
// Single-cycle bidirectional barrel shifter on 40-bit data
`timescale 1ns/1ns
`include "core_regs_defines.svh"
module barrel_shift (
    // Operand
    input  wire logic [`ACC_WIDTH-1:0] din,
    input  wire logic signed [5:0]     amount,
    // Result
    output logic [`ACC_WIDTH-1:0]      dout
);
    logic [5:0] mag;
    always_comb begin
        // Six bits so that -32 still caps instead of wrapping to zero
        mag = amount[5] ? 6'(-amount) : 6'(amount);
        if (mag > 6'(`SHIFT_MAX))
            mag = 6'(`SHIFT_MAX);
        if (amount[5])
            dout = din << mag;
        else
            dout = $signed(din) >>> mag;
    end
endmodule

// ### prog_mem_model.sv
// Program memory model answering fetch, window and table reads
`timescale 1ns/1ns
`include "core_regs_defines.svh"
module prog_mem_model (
    // Addresses from the core
    input  wire logic [`PC_WIDTH-1:0] progAddr,
    input  wire logic [`PC_WIDTH-1:0] psvProgAddr,
    input  wire logic                 psvBusy,
    // Word returned
    output logic [`INSN_WIDTH-1:0]    progData
);
    logic [`PC_WIDTH-1:0] addr;
    assign addr = psvBusy ? psvProgAddr : progAddr;
    // Top byte never zero, so a dropped upper byte is visible
    assign progData = {(8'hA5 ^ addr[7:0]) | 8'h01, addr[15:0]};
endmodule

// ### dsp_core_regs_tb.sv
// Self-checking bench for the core register model
`timescale 1ns/1ns
`include "core_regs_defines.svh"
module dsp_core_regs_tb
    import core_regs_pkg::*;
;
    typedef struct {int due; int which; logic [39:0] exp; logic [39:0] mask;} note_s;
    logic                     clk = 1'b0, rst = 1'b1;
    logic [`PC_WIDTH-1:0]     progAddr, psvProgAddr, pcTarget = '0, tgt;
    logic [`INSN_WIDTH-1:0]   progData, insnOut, dataOut;
    wreg_wr_s                 wrPort = '0;
    dmem_req_s                dReq = '0;
    logic [3:0]               rdSel = '0;
    logic                     pcLoad = 0, stall = 0, spPush = 0, spPop = 0, shadowPush = 0;
    logic                     shadowPop = 0, loopStart = 0, loopEnd = 0, srWrEn = 0;
    logic                     psvWrEn = 0, tblWrEn = 0, repeatActive = 0, tblRead = 0;
    logic                     shiftEn = 0, psvBusy, dataValid, xSel, excTaken, stackWrEn, seen;
    logic [15:0]              loopStartIn = '0, loopEndIn = '0, loopCountIn = '0;
    logic [15:0]              srWrData = '0, rdData, spOut, statusOut, stackWrAddr;
    logic [15:0]              stackWrData, data, flags, spBefore, word1;
    logic [7:0]               psvWrData = '0, tblWrData = '0, psvPageOut, statusLow;
    logic [`ACC_WIDTH-1:0]    shiftIn = '0, shiftOut;
    logic signed [5:0]        shiftAmt = '0;
    logic [`NUM_TRAPS-1:0]    trapReq = '0;
    logic [`NUM_IRQS-1:0]     irqReq = '0;
    logic [3*`NUM_IRQS-1:0]   irqPrio = '0;
    logic [5:0]               excVector;
    logic [15:0]              wmodel [16];
    logic signed [5:0]        amts [3] = '{6'sd4, -6'sd16, 6'sd16};
    logic [39:0]              shifts [3] = '{40'h0000000123, 40'h0012340000, 40'h0};
    note_s                    notes [$];
    int                       cyc = 0, mismatches = 0, checksDone = 0, seed;

    initial forever #4 clk = ~clk;
    always @(posedge clk) cyc <= cyc + 1;

    dsp_core_regs DUT (.clk, .rst, .progAddr, .progData, .wrPort, .rdSel, .pcLoad, .pcTarget,
        .stall, .spPush, .spPop, .shadowPush, .shadowPop, .loopStart, .loopEnd, .loopStartIn,
        .loopEndIn, .loopCountIn, .srWrEn, .srWrData, .psvWrEn, .psvWrData, .tblWrEn,
        .tblWrData, .repeatActive, .dReq, .tblRead, .shiftEn, .shiftIn, .shiftAmt, .trapReq,
        .irqReq, .irqPrio, .rdData, .spOut, .statusOut, .psvPageOut, .insnOut, .psvBusy,
        .psvProgAddr, .dataOut, .dataValid, .xSel, .excTaken, .excVector, .stackWrAddr,
        .stackWrData, .stackWrEn, .shiftOut);
    prog_mem_model mem (.progAddr, .psvProgAddr, .psvBusy, .progData);

    function automatic logic [39:0] pick(input int which);
        case (which)
            0: return {24'h0, rdData};
            1: return {24'h0, spOut};
            2: return {24'h0, statusOut};
            3: return {32'h0, psvPageOut};
            4: return shiftOut;
            5: return 40'(progAddr);
            7: return {39'h0, dataValid};
            8: return {39'h0, excTaken};
            default: return {39'h0, stackWrEn};
        endcase
    endfunction

    task automatic check(input logic [39:0] got, input logic [39:0] exp);
        checksDone++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: saw %h expected %h", $time, got, exp);
        end
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", checksDone, mismatches);
        if (mismatches == 0 && checksDone > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Called just after an edge; the result lands after the following edge
    task automatic expect_out(input int which, input logic [39:0] exp,
                              input logic [39:0] mask = '1);
        notes.push_back('{cyc + 2, which, exp, mask});
    endtask

    task automatic wait_for(input int which);
        for (int n = 0; n < 12; n++) begin
            @(negedge clk);
            if (pick(which) === 40'h1) return;
        end
        mismatches++;
        $display("mismatch at %0t: wait ran out", $time);
        complete_run();
    endtask

    task automatic read_all();
        for (int i = 0; i < 15; i++) begin
            @(posedge clk);
            rdSel <= 4'(i);
            expect_out(0, {24'h0, wmodel[i]});
        end
    endtask

    always @(negedge clk) begin
        while (notes.size() > 0 && notes[0].due <= cyc) begin
            check(pick(notes[0].which) & notes[0].mask, notes[0].exp & notes[0].mask);
            void'(notes.pop_front());
        end
    end

    initial begin
        repeat (5000) @(posedge clk);
        mismatches++;
        complete_run();
    end

    initial begin
        seed = 32'h9C02;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        expect_out(1, 40'h0800);
        expect_out(2, 40'h0);
        for (int i = 0; i < 15; i++) begin
            @(posedge clk);
            data = 16'($random(seed));
            wrPort <= '{1'b1, 4'(i), data, 1'b0};
            wmodel[i] = data;
        end
        @(posedge clk);
        wrPort <= '{1'b1, 4'h3, 16'hFFFF, 1'b1};
        wmodel[3][7:0] = 8'hFF;
        @(posedge clk);
        data = 16'($random(seed)) | 16'h0001;
        wrPort <= '{1'b1, 4'hF, data, 1'b0};
        expect_out(1, {24'h0, data & 16'hFFFE});
        @(posedge clk);
        wrPort <= '0;
        spPush <= 1'b1;
        expect_out(1, {24'h0, (data & 16'hFFFE) + 16'h0002});
        @(posedge clk);
        spPush <= 1'b0;
        spPop <= 1'b1;
        expect_out(1, {24'h0, data & 16'hFFFE});
        @(posedge clk);
        spPop <= 1'b0;
        read_all();
        @(posedge clk);
        flags = 16'($random(seed)) & `SHADOW_FLAGS;
        srWrEn <= 1'b1;
        srWrData <= flags;
        repeatActive <= 1'b1;
        expect_out(2, {24'h0, flags | 16'h0010});
        @(posedge clk);
        srWrEn <= 1'b0;
        shadowPush <= 1'b1;
        // Clobber W0..W3 and flags so the pop has something to undo
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            shadowPush <= 1'b0;
            srWrEn <= (i == 0);
            srWrData <= ~flags & `SHADOW_FLAGS;
            wrPort <= '{1'b1, 4'(i), ~wmodel[i], 1'b0};
        end
        @(posedge clk);
        srWrEn <= 1'b0;
        wrPort <= '0;
        shadowPop <= 1'b1;
        expect_out(2, {24'h0, flags | 16'h0010}, 40'h011F);
        @(posedge clk);
        shadowPop <= 1'b0;
        read_all();
        @(posedge clk);
        data = 16'($random(seed));
        psvWrEn <= 1'b1;
        psvWrData <= data[7:0];
        tblWrEn <= 1'b1;
        tblWrData <= data[15:8];
        loopStart <= 1'b1;
        loopStartIn <= data;
        loopEndIn <= ~data;
        loopCountIn <= 16'h0005;
        expect_out(3, {32'h0, data[7:0]});
        @(posedge clk);
        psvWrEn <= 1'b0;
        tblWrEn <= 1'b0;
        loopStart <= 1'b0;
        loopEnd <= 1'b1;
        shiftEn <= 1'b1;
        shiftIn <= 40'h0000001234;
        for (int i = 0; i < 3; i++) begin
            @(posedge clk);
            loopEnd <= 1'b0;
            shiftAmt <= amts[i];
            expect_out(4, shifts[i]);
        end
        @(posedge clk);
        shiftEn <= 1'b0;
        tgt = 23'($random(seed)) | 23'h400001;
        pcTarget <= tgt;
        pcLoad <= 1'b1;
        expect_out(5, 40'(tgt & 23'h3FFFFE));
        @(posedge clk);
        pcLoad <= 1'b0;
        expect_out(5, 40'((tgt & 23'h3FFFFE) + 23'h2));
        @(posedge clk);
        stall <= 1'b1;
        expect_out(5, 40'((tgt & 23'h3FFFFE) + 23'h2));
        @(posedge clk);
        stall <= 1'b0;
        word1 = 16'h8000 | 16'($random(seed));
        dReq <= '{1'b1, 1'b0, word1, 16'h0};
        // Window reads must be held across two sampling edges
        repeat (2) @(posedge clk);
        dReq <= '0;
        wait_for(7);
        check({32'h0, dataOut[23:16]}, 40'h0);
        check({24'h0, dataOut[15:0]}, {24'h0, data[0], word1[14:1], 1'b0});
        @(posedge clk);
        tblRead <= 1'b1;
        @(posedge clk);
        tblRead <= 1'b0;
        wait_for(7);
        check({39'h0, dataOut[23:16] != 8'h00}, 40'h1);
        @(posedge clk);
        srWrEn <= 1'b1;
        srWrData <= 16'h00E0;
        @(posedge clk);
        srWrEn <= 1'b0;
        irqPrio[15 +: 3] <= 3'd3;
        irqReq[5] <= 1'b1;
        seen = 1'b0;
        repeat (8) begin
            @(negedge clk);
            seen = seen | excTaken;
        end
        check({39'h0, seen}, 40'h0);
        @(posedge clk);
        srWrEn <= 1'b1;
        srWrData <= 16'h0000;
        irqPrio[27 +: 3] <= 3'd6;
        irqReq[9] <= 1'b1;
        @(posedge clk);
        srWrEn <= 1'b0;
        wait_for(8);
        check({34'h0, excVector}, 40'(`NUM_TRAPS + 9));
        @(negedge clk);
        check({37'h0, statusOut[7:5]}, 40'h6);
        @(posedge clk);
        irqReq <= '0;
        spBefore = spOut;
        statusLow = statusOut[7:0];
        trapReq[1] <= 1'b1;
        wait_for(9);
        word1 = stackWrData;
        check({39'h0, word1[0]}, 40'h0);
        @(posedge clk);
        trapReq <= '0;
        @(negedge clk);
        check({30'h0, stackWrData[15:6]}, {30'h0, statusLow, 2'b00});
        // Taken pulse stands in the same cycle as the second stack word
        check({39'h0, excTaken}, 40'h1);
        check({24'h0, spOut}, {24'h0, spBefore + 16'h0004});
        @(negedge clk);
        check({37'h0, statusOut[7:5]}, 40'h7);
        repeat (3) @(posedge clk);
        complete_run();
    end
endmodule
